/* hdl/blcf_top.v */
// buck configuration registers, set-point ramping and ldo overload protection
`timescale 1ns/1ns
`default_nettype none
`include "blcf_map.vh"

// Operation
// - phase code 00,01,10,11 shifts buck clock by 0,90,180,270 degrees
// - phases start at 0, 90 and 180 degrees for buck1, buck2, buck3
// - frequency code 00=1 MHz, 01=2 MHz reset, 10=4 MHz, 11 reserved
// - any phase may combine with any frequency, per buck independently
// - buck1 code: 0.700 V plus 25 mV per step; 30=1.8 V, 31=3.3 V
// - buck2 low range: 1.500 V plus 50 mV per step up to 1.850 V
// - buck2 high range codes give 2.5,2.8,2.85,3.0,3.1,3.15,3.2,3.3 V
// - buck2 range fixed at start-up; writes only move within that range
// - buck3 code: 0.90 V plus 50 mV per step up to 1.65 V
// - buck set-point registers at 0x20, 0x35, 0x3c
// - buck mode selector registers at 0x23, 0x38, 0x3f
// - config registers 0x24, 0x39, 0x40; buck2 and buck3 add current limit
// - a disabled ldo has its output pull-down switched on
// - with protection on, ldo in limit over 8.0 ms gets its enable cleared
// - the same shutoff sets that ldo's fault flag
// - each fault flag reaches the interrupt only when its mask bit is clear
// - short protection enable resets to off
// - every overload sets the fault flag regardless of protection enable
// - mode 0000 off, 0001 pwm, 0011 pfm, 1000 auto skip, reset 1000
// - target voltage moves 25 mV every 4.0 us toward new set point
module blcf_top #(
  parameter NUM_LDO      = 6,
  parameter SHORT_CYCLES = `BLCF_SHORT_TIME_US * 1000 / `BLCF_CLK_PERIOD_NS,
  parameter CNT_W        = 18,
  parameter B1_VSEL_RST  = 8'h00,
  parameter B2_VSEL_RST  = 8'h00,
  parameter B3_VSEL_RST  = 8'h00
) (
  input  wire                 i_clk,
  input  wire                 i_reset,
  input  wire                 i_ce,
  input  wire [7:0]           i_reg_addr,
  input  wire [7:0]           i_reg_wdata,
  input  wire                 i_reg_wr,
  input  wire                 i_reg_rd,
  output reg  [7:0]           o_reg_rdata,
  input  wire                 i_buck2_hi_start,
  input  wire [NUM_LDO-1:0]   i_ldo_ilim,
  output reg  [5:0]           o_buck_phase_sel,
  output reg  [11:0]          o_buck_phase_onehot,
  output reg  [5:0]           o_buck_freq_sel,
  output reg  [8:0]           o_buck_freq_onehot,
  output reg  [11:0]          o_buck_mode_onehot,
  output reg  [3:0]           o_buck_ilim,
  output reg                  o_buck2_range_hi,
  output reg  [35:0]          o_buck_target_mv,
  output reg  [NUM_LDO-1:0]   o_ldo_enable,
  output reg  [NUM_LDO-1:0]   o_ldo_pulldown,
  output reg  [NUM_LDO-1:0]   o_ldo_fault_flag,
  output reg                  o_ldo_fault_irq
);

  // step and shutoff intervals in clock cycles, cut to their counter widths on purpose
  localparam integer DVS_INT = `BLCF_DVS_STEP_NS / `BLCF_CLK_PERIOD_NS;
  localparam [6:0] DVS_CYCLES = DVS_INT[6:0];
  localparam [CNT_W-1:0] SHORT_LIM = SHORT_CYCLES[CNT_W-1:0];

  // per-buck register storage, index 0..2 is buck1..buck3
  reg  [7:0]          vsel_q  [0:2];
  reg  [7:0]          mode_q  [0:2];
  reg  [7:0]          cfg_q   [0:2];
  reg  [11:0]         cur_q   [0:2];
  reg  [11:0]         tgt_mv  [0:2];
  reg  [NUM_LDO-1:0]  en_q;
  reg  [NUM_LDO-1:0]  fault_q;
  reg  [NUM_LDO-1:0]  mask_q;
  reg                 prot_q;
  reg                 range_hi_q;
  reg                 init_q;
  reg  [6:0]          tick_q;
  reg  [NUM_LDO-1:0]  ilim_prev_q;
  reg  [7:0]          rdata_d;
  wire [NUM_LDO-1:0]  trip;
  wire                dvs_tick;
  // one loop index per process, so no index has two drivers
  integer             k;
  integer             kt;
  integer             kr;
  integer             ko;

  // offset lookup per buck
  function [7:0] vsel_off;
    input integer b;
    begin
      vsel_off = (b == 0) ? `BLCF_B1_VSEL_OFF : (b == 1) ? `BLCF_B2_VSEL_OFF : `BLCF_B3_VSEL_OFF;
    end
  endfunction

  // mode selector offset per buck
  function [7:0] mode_off;
    input integer b;
    begin
      mode_off = (b == 0) ? `BLCF_B1_MODE_OFF : (b == 1) ? `BLCF_B2_MODE_OFF : `BLCF_B3_MODE_OFF;
    end
  endfunction

  // configuration register offset per buck
  function [7:0] conf_off;
    input integer b;
    begin
      conf_off = (b == 0) ? `BLCF_B1_CONF_OFF : (b == 1) ? `BLCF_B2_CONF_OFF : `BLCF_B3_CONF_OFF;
    end
  endfunction

  // writable set-point bits per buck; bits above the code read back as zero
  function [7:0] vsel_mask;
    input integer b;
    begin
      vsel_mask = (b == 0) ? `BLCF_VSEL_MASK_B1 : (b == 1) ? `BLCF_VSEL_MASK_B2
                                                           : `BLCF_VSEL_MASK_B3;
    end
  endfunction

  // buck1 has no current-limit field in its config register
  function [7:0] cfg_mask;
    input integer b;
    begin
      cfg_mask = (b == 0) ? `BLCF_CFG_MASK_B1 : `BLCF_CFG_MASK_B23;
    end
  endfunction

  // set-point code to millivolts
  function [11:0] setpt_mv;
    input integer     b;
    input [7:0]       code;
    input             hi;
    reg   [95:0]      hi_tab;
    begin
      hi_tab = `BLCF_B2_HI_TABLE;
      setpt_mv = 12'd0;
      if (b == 0) begin
        if (code[4:0] <= `BLCF_B1_LAST_LIN)
          setpt_mv = `BLCF_B1_BASE_MV + `BLCF_B1_STEP_MV * {7'h00, code[4:0]};
        else if (code[4:0] == `BLCF_B1_CODE30)
          setpt_mv = `BLCF_B1_CODE30_MV;
        else
          setpt_mv = `BLCF_B1_CODE31_MV;
      end else if (b == 1) begin
        if (hi)
          setpt_mv = hi_tab[code[2:0]*12 +: 12];
        else
          setpt_mv = `BLCF_B2_LO_BASE_MV + `BLCF_B2_LO_STEP_MV * {9'h000, code[2:0]};
      end else begin
        setpt_mv = `BLCF_B3_BASE_MV + `BLCF_B3_STEP_MV * {8'h00, code[3:0]};
      end
    end
  endfunction

  // targets follow the stored codes; buck2 also follows the latched range
  always @* begin
    for (kt = 0; kt < 3; kt = kt + 1) begin
      tgt_mv[kt] = setpt_mv(kt, vsel_q[kt], range_hi_q);
    end
  end

  // shared 4.0 us step strobe for voltage ramping
  // it counts enabled cycles only, so a frozen block also holds its ramp
  assign dvs_tick = (tick_q == DVS_CYCLES - 7'd1);

  always @(posedge i_clk) begin
    if (i_reset) begin
      tick_q <= 7'h00;
    end else if (i_ce) begin
      tick_q <= dvs_tick ? 7'h00 : tick_q + 7'd1;
    end
  end

  // register file writes, start-up capture and ramp
  always @(posedge i_clk) begin
    if (i_reset) begin
      vsel_q[0]  <= B1_VSEL_RST;
      vsel_q[1]  <= B2_VSEL_RST;
      vsel_q[2]  <= B3_VSEL_RST;
      cfg_q[0]   <= {4'h0, `BLCF_PHASE_RST_B1, `BLCF_FREQ_RST};
      cfg_q[1]   <= {4'h0, `BLCF_PHASE_RST_B2, `BLCF_FREQ_RST};
      cfg_q[2]   <= {4'h0, `BLCF_PHASE_RST_B3, `BLCF_FREQ_RST};
      for (k = 0; k < 3; k = k + 1) begin
        mode_q[k] <= {4'h0, `BLCF_MODE_RST};
        cur_q[k]  <= 12'h000;
      end
      en_q       <= {NUM_LDO{1'b0}};
      mask_q     <= {NUM_LDO{1'b0}};
      prot_q     <= 1'b0;
      range_hi_q <= 1'b0;
      init_q     <= 1'b0;
    end else if (i_ce) begin
      // a set-point write in this first cycle lands, but the preload still uses the old code
      // the range strap is caught once, on the first cycle after reset release
      if (!init_q) begin
        init_q     <= 1'b1;
        range_hi_q <= i_buck2_hi_start;
      end
      for (k = 0; k < 3; k = k + 1) begin
        if (!init_q) begin
          cur_q[k] <= setpt_mv(k, vsel_q[k], i_buck2_hi_start);
        end else if (dvs_tick) begin
          // clamp at target so odd step sizes (buck2 high range) land exactly
          if (cur_q[k] + `BLCF_DVS_STEP_MV < tgt_mv[k])
            cur_q[k] <= cur_q[k] + `BLCF_DVS_STEP_MV;
          else if (cur_q[k] > tgt_mv[k] + `BLCF_DVS_STEP_MV)
            cur_q[k] <= cur_q[k] - `BLCF_DVS_STEP_MV;
          else
            cur_q[k] <= tgt_mv[k];
        end
        if (i_reg_wr && i_reg_addr == vsel_off(k)) begin
          vsel_q[k] <= i_reg_wdata & vsel_mask(k);
        end
        if (i_reg_wr && i_reg_addr == mode_off(k)) begin
          mode_q[k] <= {4'h0, i_reg_wdata[3:0]};
        end
        if (i_reg_wr && i_reg_addr == conf_off(k)) begin
          // phase and frequency are independent fields
          cfg_q[k][`BLCF_CFG_PHASE] <= i_reg_wdata[`BLCF_CFG_PHASE];
          // buck1 has no current-limit field, so its bits keep their reset zero
          if (k != 0)
            cfg_q[k][`BLCF_CFG_ILIM] <= i_reg_wdata[`BLCF_CFG_ILIM];
          if (i_reg_wdata[`BLCF_CFG_FREQ] != `BLCF_FREQ_RSVD)
            cfg_q[k][`BLCF_CFG_FREQ] <= i_reg_wdata[`BLCF_CFG_FREQ];
        end
      end
      // a shutoff beats a software write in the same cycle
      if (i_reg_wr && i_reg_addr == `BLCF_LDO_EN_OFF)
        en_q <= i_reg_wdata[NUM_LDO-1:0] & ~trip;
      else
        en_q <= en_q & ~trip;
      if (i_reg_wr && i_reg_addr == `BLCF_LDO_MASK_OFF)
        mask_q <= i_reg_wdata[NUM_LDO-1:0];
      if (i_reg_wr && i_reg_addr == `BLCF_LDO_PROT_OFF)
        prot_q <= i_reg_wdata[`BLCF_PROT_EN_BIT];
    end
  end

  // overload timers, one per ldo
  genvar g;
  generate
    for (g = 0; g < NUM_LDO; g = g + 1) begin : g_ldo
      reg [CNT_W-1:0] cnt_q;
      always @(posedge i_clk) begin
        if (i_reset) begin
          cnt_q <= {CNT_W{1'b0}};
        end else if (i_ce) begin
          // counter saturates so a late protection enable still trips at once
          if (i_ldo_ilim[g] && en_q[g])
            cnt_q <= (cnt_q == SHORT_LIM) ? cnt_q : cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
          else
            cnt_q <= {CNT_W{1'b0}};
        end
      end
      // trip only after the limit has been held beyond the full period
      assign trip[g] = prot_q && en_q[g] && i_ldo_ilim[g] && (cnt_q == SHORT_LIM);
    end
  endgenerate

  // fault flags: set on entry to current limit and on shutoff, set wins over clear
  // the edge detector resets low, the idle level of the limit input, so no false edge
  always @(posedge i_clk) begin
    if (i_reset) begin
      fault_q     <= {NUM_LDO{1'b0}};
      ilim_prev_q <= {NUM_LDO{1'b0}};
    end else if (i_ce) begin
      ilim_prev_q <= i_ldo_ilim;
      if (i_reg_wr && i_reg_addr == `BLCF_LDO_FAULT_OFF)
        fault_q <= (fault_q & ~i_reg_wdata[NUM_LDO-1:0]) | trip
                   | (i_ldo_ilim & ~ilim_prev_q);
      else
        fault_q <= fault_q | trip | (i_ldo_ilim & ~ilim_prev_q);
    end
  end

  // read mux; unmapped addresses read zero
  always @* begin
    rdata_d = 8'h00;
    for (kr = 0; kr < 3; kr = kr + 1) begin
      if (i_reg_addr == vsel_off(kr))
        rdata_d = vsel_q[kr];
      if (i_reg_addr == mode_off(kr))
        rdata_d = mode_q[kr];
      if (i_reg_addr == conf_off(kr))
        rdata_d = cfg_q[kr] & cfg_mask(kr);
    end
    case (i_reg_addr)
      `BLCF_LDO_EN_OFF:    rdata_d = {{(8-NUM_LDO){1'b0}}, en_q};
      `BLCF_LDO_FAULT_OFF: rdata_d = {{(8-NUM_LDO){1'b0}}, fault_q};
      `BLCF_LDO_MASK_OFF:  rdata_d = {{(8-NUM_LDO){1'b0}}, mask_q};
      `BLCF_LDO_PROT_OFF:  rdata_d = {7'h00, prot_q};
      default:             rdata_d = rdata_d;
    endcase
  end

  // registered outputs: read data and decoded controls
  always @(posedge i_clk) begin
    if (i_reset) begin
      o_reg_rdata         <= 8'h00;
      o_buck_phase_sel    <= 6'h00;
      o_buck_phase_onehot <= 12'h000;
      o_buck_freq_sel     <= 6'h00;
      o_buck_freq_onehot  <= 9'h000;
      o_buck_mode_onehot  <= 12'h000;
      o_buck_ilim         <= 4'h0;
      o_buck2_range_hi    <= 1'b0;
      o_buck_target_mv    <= 36'h000000000;
      o_ldo_enable        <= {NUM_LDO{1'b0}};
      o_ldo_pulldown      <= {NUM_LDO{1'b1}};
      o_ldo_fault_flag    <= {NUM_LDO{1'b0}};
      o_ldo_fault_irq     <= 1'b0;
    end else if (i_ce) begin
      // read data holds between reads, so the host may take it late
      if (i_reg_rd)
        o_reg_rdata <= rdata_d;
      for (ko = 0; ko < 3; ko = ko + 1) begin
        o_buck_phase_sel[ko*2 +: 2] <= cfg_q[ko][`BLCF_CFG_PHASE];
        o_buck_freq_sel[ko*2 +: 2]  <= cfg_q[ko][`BLCF_CFG_FREQ];
        // one-hot bit n means n*90 degrees of shift
        o_buck_phase_onehot[ko*4 +: 4] <= 4'h1 << cfg_q[ko][`BLCF_CFG_PHASE];
        // bits are 1, 2, 4 MHz; the reserved code can never be stored
        o_buck_freq_onehot[ko*3 +: 3] <= 3'h1 << cfg_q[ko][`BLCF_CFG_FREQ];
        // bits are off, pwm, pfm, auto skip; other codes light none
        case (mode_q[ko][3:0])
          `BLCF_MODE_OFF: o_buck_mode_onehot[ko*4 +: 4] <= 4'h1;
          `BLCF_MODE_PWM: o_buck_mode_onehot[ko*4 +: 4] <= 4'h2;
          `BLCF_MODE_PFM: o_buck_mode_onehot[ko*4 +: 4] <= 4'h4;
          `BLCF_MODE_APS: o_buck_mode_onehot[ko*4 +: 4] <= 4'h8;
          default:        o_buck_mode_onehot[ko*4 +: 4] <= 4'h0;
        endcase
        o_buck_target_mv[ko*12 +: 12] <= cur_q[ko];
      end
      o_buck_ilim      <= {cfg_q[2][`BLCF_CFG_ILIM], cfg_q[1][`BLCF_CFG_ILIM]};
      o_buck2_range_hi <= range_hi_q;
      o_ldo_enable     <= en_q;
      o_ldo_pulldown   <= ~en_q;
      o_ldo_fault_flag <= fault_q;
      o_ldo_fault_irq  <= |(fault_q & ~mask_q);
    end
  end

endmodule // blcf_top
`default_nettype wire

/* pkg/blcf_map.vh */
// register map, field layout, reset values and timing constants for the buck/ldo block
`ifndef BLCF_MAP_VH
`define BLCF_MAP_VH

// register offsets
`define BLCF_B1_VSEL_OFF     8'h20
`define BLCF_B1_MODE_OFF     8'h23
`define BLCF_B1_CONF_OFF     8'h24
`define BLCF_B2_VSEL_OFF     8'h35
`define BLCF_B2_MODE_OFF     8'h38
`define BLCF_B2_CONF_OFF     8'h39
`define BLCF_B3_VSEL_OFF     8'h3c
`define BLCF_B3_MODE_OFF     8'h3f
`define BLCF_B3_CONF_OFF     8'h40
`define BLCF_LDO_EN_OFF      8'h60
`define BLCF_LDO_FAULT_OFF   8'h61
`define BLCF_LDO_MASK_OFF    8'h62
`define BLCF_LDO_PROT_OFF    8'h63

// configuration register fields
`define BLCF_CFG_FREQ        1:0
`define BLCF_CFG_PHASE       3:2
`define BLCF_CFG_ILIM        5:4
`define BLCF_CFG_MASK_B1     8'h0f
`define BLCF_CFG_MASK_B23    8'h3f
`define BLCF_PROT_EN_BIT     0

// set-point code masks
`define BLCF_VSEL_MASK_B1    8'h1f
`define BLCF_VSEL_MASK_B2    8'h07
`define BLCF_VSEL_MASK_B3    8'h0f
`define BLCF_LDO_MASK6       8'h3f

// codes and reset values
`define BLCF_FREQ_RSVD       2'h3
`define BLCF_FREQ_RST        2'h1
`define BLCF_PHASE_RST_B1    2'h0
`define BLCF_PHASE_RST_B2    2'h1
`define BLCF_PHASE_RST_B3    2'h2
`define BLCF_MODE_OFF        4'h0
`define BLCF_MODE_PWM        4'h1
`define BLCF_MODE_PFM        4'h3
`define BLCF_MODE_APS        4'h8
`define BLCF_MODE_RST        4'h8

// set-point voltages in millivolts
`define BLCF_B1_BASE_MV      12'd700
`define BLCF_B1_STEP_MV      12'd25
`define BLCF_B1_LAST_LIN     5'h1d
`define BLCF_B1_CODE30       5'h1e
`define BLCF_B1_CODE30_MV    12'd1800
`define BLCF_B1_CODE31_MV    12'd3300
`define BLCF_B2_LO_BASE_MV   12'd1500
`define BLCF_B2_LO_STEP_MV   12'd50
`define BLCF_B2_HI_TABLE     {12'd3300, 12'd3200, 12'd3150, 12'd3100, 12'd3000, 12'd2850, 12'd2800, 12'd2500}
`define BLCF_B3_BASE_MV      12'd900
`define BLCF_B3_STEP_MV      12'd50
`define BLCF_DVS_STEP_MV     12'd25

// timing
`define BLCF_CLK_PERIOD_NS   40
`define BLCF_DVS_STEP_NS     4000
`define BLCF_SHORT_TIME_US   8000

`endif

/* bench/blcf_top_sva.sv */
// port assertions for the buck/ldo configuration block
`timescale 1ns/1ns
`default_nettype none
`include "blcf_map.vh"
module blcf_top_sva #(
  parameter SHORT_CYCLES = `BLCF_SHORT_TIME_US * 1000 / `BLCF_CLK_PERIOD_NS
) (
  input wire logic        i_clk,
  input wire logic        i_reset,
  input wire logic        i_ce,
  input wire logic [7:0]  i_reg_addr,
  input wire logic [7:0]  i_reg_wdata,
  input wire logic        i_reg_wr,
  input wire logic [5:0]  i_ldo_ilim,
  input wire logic [5:0]  o_buck_phase_sel,
  input wire logic [11:0] o_buck_phase_onehot,
  input wire logic [5:0]  o_buck_freq_sel,
  input wire logic        o_buck2_range_hi,
  input wire logic [35:0] o_buck_target_mv,
  input wire logic [5:0]  o_ldo_enable,
  input wire logic [5:0]  o_ldo_pulldown,
  input wire logic [5:0]  o_ldo_fault_flag,
  input wire logic        o_ldo_fault_irq
);
  logic [7:0]  since_q;
  logic [17:0] run_q;
  logic [11:0] prev_q;
  logic [11:0] delta;
  // edges since reset and length of the ldo0 overload; decoded outputs lag reset by one edge
  always_ff @(posedge i_clk) begin
    since_q <= i_reset ? 8'h00 : since_q + {7'h0, since_q != 8'hff};
    run_q   <= (i_reset || !i_ldo_ilim[0]) ? 18'h00000 : run_q + {17'h0, i_ce};
    prev_q  <= o_buck_target_mv[11:0];
  end
  assign delta = (o_buck_target_mv[11:0] > prev_q) ? o_buck_target_mv[11:0] - prev_q
                                                   : prev_q - o_buck_target_mv[11:0];
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  AST_PULLDOWN: assert property (o_ldo_pulldown == ~o_ldo_enable)
    else $error("ldo pull-down is not the inverse of its enable");
  AST_PHASE: assert property (since_q > 8'h02 |-> o_buck_phase_onehot ==
    {4'h1 << o_buck_phase_sel[5:4], 4'h1 << o_buck_phase_sel[3:2], 4'h1 << o_buck_phase_sel[1:0]})
    else $error("phase decode does not match phase code");
  AST_FREQ: assert property (o_buck_freq_sel[1:0] != 2'h3 && o_buck_freq_sel[3:2] != 2'h3
    && o_buck_freq_sel[5:4] != 2'h3) else $error("reserved frequency code reached an output");
  AST_FLAG_SET: assert property ($rose(i_ldo_ilim[0]) && i_ce |-> ##2 o_ldo_fault_flag[0])
    else $error("overload did not raise the fault flag");
  AST_SHUTOFF: assert property ($fell(o_ldo_enable[0])
    && !$past(i_reg_wr && i_reg_addr == `BLCF_LDO_EN_OFF, 2)
    |-> o_ldo_fault_flag[0] && run_q >= SHORT_CYCLES) else $error("ldo shut off wrongly");
  AST_STICKY: assert property ($fell(o_ldo_fault_flag[0]) |->
    $past(i_reg_wr && i_reg_addr == `BLCF_LDO_FAULT_OFF && i_reg_wdata[0], 2))
    else $error("fault flag dropped without a clear");
  AST_RANGE: assert property ($changed(o_buck2_range_hi) |-> since_q < 8'h04)
    else $error("buck2 range changed after start-up");
  AST_RAMP: assert property (since_q > 8'h04 && delta != 12'h000 |->
    delta <= 12'd25 ##1 $stable(o_buck_target_mv[11:0])[*8]) else $error("ramp step wrong");
  AST_IRQ: assert property (o_ldo_fault_irq |->
    (|o_ldo_fault_flag) || $past(|o_ldo_fault_flag)) else $error("interrupt with no fault");
endmodule // blcf_top_sva
bind blcf_top blcf_top_sva #(.SHORT_CYCLES(SHORT_CYCLES)) blcf_top_sva_inst (
  .i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_ldo_ilim(i_ldo_ilim),
  .o_buck_phase_sel(o_buck_phase_sel), .o_buck_phase_onehot(o_buck_phase_onehot),
  .o_buck_freq_sel(o_buck_freq_sel), .o_buck2_range_hi(o_buck2_range_hi),
  .o_buck_target_mv(o_buck_target_mv), .o_ldo_enable(o_ldo_enable),
  .o_ldo_pulldown(o_ldo_pulldown), .o_ldo_fault_flag(o_ldo_fault_flag),
  .o_ldo_fault_irq(o_ldo_fault_irq));
`default_nettype wire

/* bench/blcf_host_model.sv */
// register-port host model: one access at a time, lines scrambled when idle
`timescale 1ns/1ns
`default_nettype none
module blcf_host_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output var  logic [7:0] o_addr,
  output var  logic [7:0] o_wdata,
  output var  logic       o_wr,
  output var  logic       o_rd
);
  initial begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // idle address and data are inverted so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    #1 d = i_rdata;
  endtask
endmodule // blcf_host_model
`default_nettype wire

/* bench/testbench.sv */
// self-checking testbench for the buck/ldo configuration block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct packed {logic [7:0] a; logic w; logic [7:0] d; logic [7:0] e;} blcf_row_t;
  // reset reads, then write and read back: address, write, data, expected read
  blcf_row_t rows [20] = '{
    '{8'h24, 1'b0, 8'h00, 8'h01}, '{8'h39, 1'b0, 8'h00, 8'h05}, '{8'h40, 1'b0, 8'h00, 8'h09},
    '{8'h23, 1'b0, 8'h00, 8'h08}, '{8'h38, 1'b0, 8'h00, 8'h08}, '{8'h3f, 1'b0, 8'h00, 8'h08},
    '{8'h63, 1'b0, 8'h00, 8'h00}, '{8'h24, 1'b1, 8'h0e, 8'h0e}, '{8'h39, 1'b1, 8'h3c, 8'h3c},
    '{8'h40, 1'b1, 8'h29, 8'h29}, '{8'h24, 1'b1, 8'hff, 8'h0e}, '{8'h23, 1'b1, 8'h01, 8'h01},
    '{8'h38, 1'b1, 8'h03, 8'h03}, '{8'h3f, 1'b1, 8'h00, 8'h00}, '{8'h23, 1'b1, 8'hf8, 8'h08},
    '{8'h20, 1'b1, 8'hff, 8'h1f}, '{8'h35, 1'b1, 8'hff, 8'h07}, '{8'h3c, 1'b1, 8'hff, 8'h0f},
    '{8'h10, 1'b1, 8'haa, 8'h00}, '{8'h63, 1'b1, 8'h01, 8'h01}};
  logic        i_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic        i_ce = 1'b1;
  logic        i_buck2_hi_start = 1'b0;
  logic [5:0]  i_ldo_ilim = 6'h00;
  wire  [7:0]  addr, wdata, rdata;
  wire         wr, rd, rng, irq;
  wire  [5:0]  phs, frq, en, pd, flg;
  wire  [11:0] phoh, mdoh;
  wire  [8:0]  fqoh;
  wire  [3:0]  ilim;
  wire  [35:0] tgt;
  int          err_total = 0;
  int          checked = 0;
  int          n;
  logic [7:0]  d;
  always #20 i_clk = ~i_clk;
  blcf_host_model blcf_host_model_inst (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  blcf_top #(.SHORT_CYCLES(20)) blcf_top_inst (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .i_buck2_hi_start(i_buck2_hi_start), .i_ldo_ilim(i_ldo_ilim), .o_buck_phase_sel(phs),
    .o_buck_phase_onehot(phoh), .o_buck_freq_sel(frq), .o_buck_freq_onehot(fqoh),
    .o_buck_mode_onehot(mdoh), .o_buck_ilim(ilim), .o_buck2_range_hi(rng),
    .o_buck_target_mv(tgt), .o_ldo_enable(en), .o_ldo_pulldown(pd), .o_ldo_fault_flag(flg),
    .o_ldo_fault_irq(irq));
  task automatic cmp(input string nm, input logic [35:0] e, input logic [35:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] v);
    blcf_host_model_inst.wr(a, v);
  endtask
  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // main sequence; ramp waits follow the fixed 25 mV per 100-cycle stepping
  initial begin
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (3) @(posedge i_clk);
    #1 cmp("phase_oh", 12'h421, phoh);
    cmp("freq_oh", 9'h092, fqoh);
    cmp("mode_oh", 12'h888, mdoh);
    cmp("target", {12'd900, 12'd1500, 12'd700}, tgt);
    foreach (rows[k]) begin
      if (rows[k].w) w(rows[k].a, rows[k].d);
      blcf_host_model_inst.rd(rows[k].a, d);
      cmp("register", rows[k].e, d);
    end
    repeat (2) @(posedge i_clk);
    #1 cmp("phase_sel", 6'h2f, phs);
    cmp("phase_oh", 12'h488, phoh);
    cmp("freq_sel", 6'h12, frq);
    cmp("freq_oh", 9'h08c, fqoh);
    cmp("ilim", 4'hb, ilim);
    cmp("mode_oh", 12'h148, mdoh);
    repeat (10600) @(posedge i_clk);
    #1 cmp("target", {12'd1650, 12'd1850, 12'd3300}, tgt);
    $display("test registers and ramp finished");
    w(8'h60, 8'h3f);
    w(8'h62, 8'h02);
    i_ldo_ilim <= 6'h02;
    repeat (3) @(posedge i_clk);
    i_ldo_ilim <= 6'h01;
    #1 cmp("enable", 6'h3f, en);
    cmp("fault_masked", {6'h02, 1'b0}, {flg, irq});
    n = 0;
    while (en[0] === 1'b1 && n < 100) begin
      @(posedge i_clk);
      #1 n++;
    end
    cmp("shutoff_cycles", 22, n);
    if (n >= 100) summarize();
    cmp("after_shutoff", {6'h3e, 6'h01, 6'h03, 1'b1}, {en, pd, flg, irq});
    @(posedge i_clk);
    i_ldo_ilim <= 6'h00;
    repeat (5) @(posedge i_clk);
    #1 cmp("sticky", 6'h03, flg);
    w(8'h61, 8'h01);
    repeat (2) @(posedge i_clk);
    #1 cmp("cleared", {6'h02, 1'b0}, {flg, irq});
    w(8'h63, 8'h00);
    w(8'h60, 8'h3f);
    i_ldo_ilim <= 6'h04;
    repeat (40) @(posedge i_clk);
    #1 cmp("no_protect", {6'h3f, 6'h06}, {en, flg});
    $display("test ldo protection finished");
    @(posedge i_clk);
    i_ldo_ilim <= 6'h00;
    i_buck2_hi_start <= 1'b1;
    i_reset <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_buck2_hi_start <= 1'b0;
    #1 cmp("range", {1'b1, 12'd2500}, {rng, tgt[23:12]});
    w(8'h20, 8'h1e);
    w(8'h35, 8'h02);
    w(8'h3c, 8'h05);
    repeat (5000) @(posedge i_clk);
    #1 cmp("range_hi", 1'b1, rng);
    cmp("target_hi", {12'd1150, 12'd2850, 12'd1800}, tgt);
    // with the clock enable low a write must not land
    @(posedge i_clk);
    i_ce <= 1'b0;
    w(8'h3c, 8'h0f);
    i_ce <= 1'b1;
    blcf_host_model_inst.rd(8'h3c, d);
    cmp("frozen_write", 8'h05, d);
    $display("test high range finished");
    summarize();
  end
endmodule // testbench
`default_nettype wire
